// >>> inc/tcd_defines.vh
// tcd_defines.vh: address fields, reset values and timing counts of the cache directory control
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH
`define TCD_LINE_LSB      2
`define TCD_LINE_MSB      4
`define TCD_SET_LSB       5
`define TCD_SET_MSB       13
`define TCD_TAG_LSB       14
`define TCD_TAG_MSB       31
`define TCD_DM_BANK_BIT   14
`define TCD_COPROC_BIT    31
`define TCD_LRU_RST       1'b0
`define TCD_PHASE_RST     1'b0
`define TCD_SYNC_STAGES   2
`endif

// >>> verilog/tcd_dir_ram.v
// tcd_dir_ram: one bank of directory entries (tag and line valid bits), registered read
`timescale 1ns/1ps
module tcd_dir_ram #(
  parameter AW = 9,
  parameter DW = 26
) (
  input  wire          i_clk_sys, // double-rate clock
  input  wire          i_we,      // write strobe
  input  wire [AW-1:0] i_waddr,   // write set index
  input  wire [DW-1:0] i_wdata,   // write entry
  input  wire [AW-1:0] i_raddr,   // read set index
  output reg  [DW-1:0] o_rdata    // read entry, one cycle after address
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // no reset: contents are qualified by the tag valid flops outside
  always @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule // tcd_dir_ram

// >>> verilog/tcd_phase_gen.v
// tcd_phase_gen: reset release synchroniser and divide-by-two phase clock
`timescale 1ns/1ps
`include "tcd_defines.vh"
module tcd_phase_gen (
  input  wire i_clk_sys, // double-rate clock
  input  wire i_nrst,    // asynchronous reset, active low
  output reg  o_phase,   // 0 in phase_one, 1 in phase_two
  output wire o_run      // synchronised reset release
);
  reg [`TCD_SYNC_STAGES-1:0] sync_r;

  assign o_run = sync_r[`TCD_SYNC_STAGES-1];

  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync_r <= {`TCD_SYNC_STAGES{1'b0}};
    end
    else
    begin
      sync_r <= {sync_r[`TCD_SYNC_STAGES-2:0], 1'b1};
    end
  end

  // held in phase_one until release, so the second phase after release is phase_two
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_phase <= `TCD_PHASE_RST;
    end
    else if (!o_run)
    begin
      o_phase <= `TCD_PHASE_RST; // RL6
    end
    else
    begin
      o_phase <= ~o_phase; // RL5
    end
  end
endmodule // tcd_phase_gen

// >>> verilog/tcd_ctrl.v
// tcd_ctrl: directory, replacement and cache strobe control for a two-way or direct mapped cache
// Operation
// RL1: write hit writes the hitting bank
// RL2: write hit points replacement at other bank
// RL3: snoop invalidation points replacement at that bank
// RL4: reset or flush clears all tag valids
// RL5: divide double-rate clock into two phases
// RL6: reset release aligns second phase to phase_two
// RL7: compare tag, use byte enables, classify cycle
// RL8: track processor cycles by strobe and ready
// RL9: drive next address request for pipelining
// RL10: own ready ends all but local, forwarded reads
// RL11: local resources terminate their own cycles
// RL12: forwarded reads gate system ready to processor
// RL13: address latch enable high means transparent
// RL14: transceiver direction high drives processor bus
// RL15: four active-low byte selects, lowest byte first
// RL16: read hits and fills select all bytes
// RL17: write hit selects only enabled bytes
// RL18: style low: output enable on read hits
// RL19: style high: enable on hits and fills
// RL20: write enable on fills and write hits
// RL21: sample decodes when new address first valid
// RL22: read hit points replacement at other bank
// RL23: tag miss fills replacement bank, rewrites entry
`timescale 1ns/1ps
`include "tcd_defines.vh"
module tcd_ctrl #(
  parameter SET_W = 9,
  parameter TAG_W = 18,
  parameter LINES = 8
) (
  input  wire        i_clk_sys,             // double-rate clock
  input  wire        i_nrst,                // asynchronous reset, active low
  input  wire [31:2] i_cpu_addr,            // processor address
  input  wire [3:0]  i_cpu_byte_en_n,       // processor byte enables
  input  wire        i_cpu_mio,             // memory (1) or io (0)
  input  wire        i_cpu_wr,              // write (1) or read (0)
  input  wire        i_cpu_addr_strobe_n,   // address strobe
  input  wire        i_cpu_ready_in_n,      // shared ready
  input  wire        i_local_acc_n,         // local resource decode
  input  wire        i_non_cache_n,         // non-cacheable decode
  input  wire        i_bus16_n,             // 16-bit space decode
  input  wire        i_two_way,             // 1 two-way, 0 direct mapped
  input  wire        i_out_en_style_sel_n,  // output enable style
  input  wire        i_flush,               // flush request level
  input  wire        i_snoop_req,           // snoop hit candidate pulse
  input  wire [31:2] i_snoop_addr,          // snooped system address
  output wire        o_phase_clk,           // internal phase clock
  output reg         o_ctrl_ready_out_n,    // ready to processor
  output reg         o_sys_ready_gate_n,    // gate system ready
  output reg         o_next_addr_req_n,     // next address request
  output reg         o_cache_addr_latch_en, // cache address latch enable
  output reg         o_cache_xcvr_dir,      // transceiver direction
  output reg  [3:0]  o_cache_byte_sel_n,    // cache byte chip selects
  output reg         o_bank_a_out_en_n,     // bank a output enable
  output reg         o_bank_b_out_en_n,     // bank b output enable
  output reg         o_bank_a_wr_en_n,      // bank a write enable
  output reg         o_bank_b_wr_en_n       // bank b write enable
);
  localparam SETS = 1 << SET_W;
  localparam DW   = TAG_W + LINES;
  localparam [1:0] M_IDLE = 2'd0;
  localparam [1:0] M_LOOK = 2'd1;
  localparam [1:0] M_CHK  = 2'd2;
  localparam [1:0] M_RUN  = 2'd3;
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_RD   = 2'd1;
  localparam [1:0] S_WR   = 2'd2;

  wire          phase;
  wire          run;
  reg  [1:0]    m_state_r;
  reg  [1:0]    s_state_r;
  reg           pend_r;
  reg  [31:2]   cap_addr_r;
  reg  [3:0]    cap_be_n_r;
  reg           cap_mio_r;
  reg           cap_wr_r;
  reg           cap_lba_n_r;
  reg           cap_nca_n_r;
  reg           cap_x16_n_r;
  reg  [31:2]   cur_addr_r;
  reg  [3:0]    cur_be_n_r;
  reg           cur_mio_r;
  reg           cur_wr_r;
  reg           cur_lba_n_r;
  reg           cur_nca_n_r;
  reg           cur_x16_n_r;
  reg           fill_r;
  reg           fill_b_r;
  reg  [LINES-1:0] fill_lv_r;
  reg           snp_pend_r;
  reg  [31:2]   snp_q_r;
  reg  [31:2]   snp_cur_r;
  reg  [SETS-1:0] tv_a_r;
  reg  [SETS-1:0] tv_b_r;
  reg  [SETS-1:0] lru_r;
  wire [DW-1:0] rd_a;
  wire [DW-1:0] rd_b;

  assign o_phase_clk = phase;

  // the last double-rate cycle of every state is its phase_two
  wire st_end  = run & phase;
  wire ads_now = st_end & ~i_cpu_addr_strobe_n;
  wire done    = (m_state_r == M_RUN) & st_end & ~i_cpu_ready_in_n;

  wire [SET_W-1:0] cur_set  = cur_addr_r[`TCD_SET_MSB:`TCD_SET_LSB];
  wire [TAG_W-1:0] cur_tag  = cur_addr_r[`TCD_TAG_MSB:`TCD_TAG_LSB];
  wire [2:0]       cur_line = cur_addr_r[`TCD_LINE_MSB:`TCD_LINE_LSB];
  wire [SET_W-1:0] snp_set  = snp_cur_r[`TCD_SET_MSB:`TCD_SET_LSB];
  wire [TAG_W-1:0] snp_tag  = snp_cur_r[`TCD_TAG_MSB:`TCD_TAG_LSB];
  wire [2:0]       snp_line = snp_cur_r[`TCD_LINE_MSB:`TCD_LINE_LSB];

  // direct mapped uses the tag's low bit as bank, so the same compare serves both modes
  wire tagm_a = tv_a_r[cur_set] & (rd_a[DW-1:LINES] == cur_tag); // RL7
  wire tagm_b = tv_b_r[cur_set] & (rd_b[DW-1:LINES] == cur_tag); // RL7
  wire hit_a  = tagm_a & rd_a[cur_line];
  wire hit_b  = tagm_b & rd_b[cur_line];
  wire hit    = hit_a | hit_b;

  wire local_c = ~cur_lba_n_r | (~cur_mio_r & cur_addr_r[`TCD_COPROC_BIT]); // RL7 RL11
  wire cach_c  = cur_mio_r & cur_nca_n_r & cur_x16_n_r & ~local_c;         // RL7
  wire rd_hit  = ~cur_wr_r & cach_c & hit;
  wire rd_miss = ~cur_wr_r & cach_c & ~hit;
  wire wr_hit  = cur_wr_r & cach_c & hit;
  wire fwd_rd  = ~cur_wr_r & ~local_c & ~rd_hit;
  wire fill_b  = tagm_a ? 1'b0 :
                 tagm_b ? 1'b1 :
                 i_two_way ? lru_r[cur_set] : cur_addr_r[`TCD_DM_BANK_BIT]; // RL23
  wire use_b   = (rd_hit | wr_hit) ? hit_b : fill_b;
  wire oe_on   = i_out_en_style_sel_n ? (rd_hit | rd_miss | wr_hit) : rd_hit; // RL18 RL19
  wire we_on   = rd_miss | wr_hit;                                            // RL20

  wire snp_hit_a = tv_a_r[snp_set] & (rd_a[DW-1:LINES] == snp_tag) & rd_a[snp_line];
  wire snp_hit_b = tv_b_r[snp_set] & (rd_b[DW-1:LINES] == snp_tag) & rd_b[snp_line];
  wire snp_wr    = (s_state_r == S_WR);
  wire fill_now  = done & fill_r;
  wire s_start   = run & (s_state_r == S_IDLE) & snp_pend_r & (m_state_r == M_IDLE) & ~ads_now;

  wire [LINES-1:0] line_oh = {{(LINES-1){1'b0}}, 1'b1} << cur_line;
  wire [LINES-1:0] snp_oh  = {{(LINES-1){1'b0}}, 1'b1} << snp_line;
  wire [DW-1:0]    fill_wd = {cur_tag, fill_lv_r | line_oh}; // RL23
  wire             we_a    = (snp_wr & snp_hit_a) | (fill_now & ~fill_b_r);
  wire             we_b    = (snp_wr & snp_hit_b) | (fill_now & fill_b_r);
  wire [SET_W-1:0] waddr   = snp_wr ? snp_set : cur_set;
  wire [DW-1:0]    wd_a    = snp_wr ? {rd_a[DW-1:LINES], rd_a[LINES-1:0] & ~snp_oh} : fill_wd; // RL3
  wire [DW-1:0]    wd_b    = snp_wr ? {rd_b[DW-1:LINES], rd_b[LINES-1:0] & ~snp_oh} : fill_wd; // RL3
  wire [SET_W-1:0] raddr   = (s_state_r == S_RD) ? snp_set : cap_addr_r[`TCD_SET_MSB:`TCD_SET_LSB];

  tcd_phase_gen u_phase (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .o_phase   (phase),
    .o_run     (run)
  );

  tcd_dir_ram #(.AW(SET_W), .DW(DW)) u_dir_a (
    .i_clk_sys (i_clk_sys),
    .i_we      (we_a),
    .i_waddr   (waddr),
    .i_wdata   (wd_a),
    .i_raddr   (raddr),
    .o_rdata   (rd_a)
  );

  tcd_dir_ram #(.AW(SET_W), .DW(DW)) u_dir_b (
    .i_clk_sys (i_clk_sys),
    .i_we      (we_b),
    .i_waddr   (waddr),
    .i_wdata   (wd_b),
    .i_raddr   (raddr),
    .o_rdata   (rd_b)
  );

  // processor cycle tracking and cache strobes
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      m_state_r             <= M_IDLE;
      pend_r                <= 1'b0;
      cap_addr_r            <= 30'h0;
      cap_be_n_r            <= 4'hf;
      cap_mio_r             <= 1'b0;
      cap_wr_r              <= 1'b0;
      cap_lba_n_r           <= 1'b1;
      cap_nca_n_r           <= 1'b1;
      cap_x16_n_r           <= 1'b1;
      cur_addr_r            <= 30'h0;
      cur_be_n_r            <= 4'hf;
      cur_mio_r             <= 1'b0;
      cur_wr_r              <= 1'b0;
      cur_lba_n_r           <= 1'b1;
      cur_nca_n_r           <= 1'b1;
      cur_x16_n_r           <= 1'b1;
      fill_r                <= 1'b0;
      fill_b_r              <= 1'b0;
      fill_lv_r             <= {LINES{1'b0}};
      o_ctrl_ready_out_n    <= 1'b1;
      o_sys_ready_gate_n    <= 1'b1;
      o_next_addr_req_n     <= 1'b1;
      o_cache_addr_latch_en <= 1'b1;
      o_cache_xcvr_dir      <= 1'b0;
      o_cache_byte_sel_n    <= 4'hf;
      o_bank_a_out_en_n     <= 1'b1;
      o_bank_b_out_en_n     <= 1'b1;
      o_bank_a_wr_en_n      <= 1'b1;
      o_bank_b_wr_en_n      <= 1'b1;
    end
    else
    begin
      // address state or pipelined second state: first end with a valid new address
      if (ads_now & ((m_state_r == M_IDLE) | (m_state_r == M_RUN)))
      begin
        cap_addr_r  <= i_cpu_addr;      // RL21
        cap_be_n_r  <= i_cpu_byte_en_n;
        cap_mio_r   <= i_cpu_mio;
        cap_wr_r    <= i_cpu_wr;
        cap_lba_n_r <= i_local_acc_n;   // RL21
        cap_nca_n_r <= i_non_cache_n;   // RL21
        cap_x16_n_r <= i_bus16_n;       // RL21
      end
      case (m_state_r)
        M_IDLE:
        begin
          if (ads_now)
          begin
            m_state_r <= M_LOOK; // RL8
          end
        end
        M_LOOK:
        begin
          // wait out a snoop so the lookup sees its invalidation
          if (s_state_r == S_IDLE)
          begin
            cur_addr_r            <= cap_addr_r;
            cur_be_n_r            <= cap_be_n_r;
            cur_mio_r             <= cap_mio_r;
            cur_wr_r              <= cap_wr_r;
            cur_lba_n_r           <= cap_lba_n_r;
            cur_nca_n_r           <= cap_nca_n_r;
            cur_x16_n_r           <= cap_x16_n_r;
            o_cache_addr_latch_en <= 1'b0; // RL13
            m_state_r             <= M_CHK;
          end
        end
        M_CHK:
        begin
          fill_r             <= rd_miss;
          fill_b_r           <= fill_b;
          fill_lv_r          <= tagm_a ? rd_a[LINES-1:0] : tagm_b ? rd_b[LINES-1:0] : {LINES{1'b0}}; // RL23
          o_ctrl_ready_out_n <= local_c | fwd_rd; // RL10 RL11
          o_sys_ready_gate_n <= ~fwd_rd;          // RL12
          o_next_addr_req_n  <= local_c;          // RL9
          o_cache_xcvr_dir   <= rd_hit;           // RL14
          if (rd_hit | rd_miss)
          begin
            o_cache_byte_sel_n <= 4'h0;           // RL15 RL16
          end
          else if (wr_hit)
          begin
            o_cache_byte_sel_n <= cur_be_n_r;     // RL1 RL17
          end
          else
          begin
            o_cache_byte_sel_n <= 4'hf;
          end
          o_bank_a_out_en_n <= ~(oe_on & (~i_two_way | ~use_b)); // RL18 RL19
          o_bank_b_out_en_n <= ~(oe_on & (~i_two_way | use_b));  // RL18 RL19
          o_bank_a_wr_en_n  <= ~(we_on & (~i_two_way | ~use_b)); // RL1 RL20
          o_bank_b_wr_en_n  <= ~(we_on & (~i_two_way | use_b));  // RL1 RL20
          m_state_r         <= M_RUN;
        end
        M_RUN:
        begin
          if (ads_now)
          begin
            pend_r <= 1'b1;
          end
          if (done)
          begin
            o_ctrl_ready_out_n    <= 1'b1;
            o_sys_ready_gate_n    <= 1'b1;
            o_next_addr_req_n     <= 1'b1;
            o_cache_addr_latch_en <= 1'b1; // RL13
            o_cache_xcvr_dir      <= 1'b0;
            o_cache_byte_sel_n    <= 4'hf;
            o_bank_a_out_en_n     <= 1'b1;
            o_bank_b_out_en_n     <= 1'b1;
            o_bank_a_wr_en_n      <= 1'b1;
            o_bank_b_wr_en_n      <= 1'b1;
            pend_r                <= 1'b0;
            m_state_r             <= (pend_r | ads_now) ? M_LOOK : M_IDLE; // RL8
          end
        end
        default:
        begin
          m_state_r <= M_IDLE;
        end
      endcase
    end
  end

  // snoop service: only between processor cycles, one request waits, a newer request replaces its address
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_state_r  <= S_IDLE;
      snp_pend_r <= 1'b0;
      snp_q_r    <= 30'h0;
      snp_cur_r  <= 30'h0;
    end
    else
    begin
      snp_pend_r <= i_snoop_req | (snp_pend_r & ~s_start);
      if (i_snoop_req)
      begin
        snp_q_r <= i_snoop_addr;
      end
      case (s_state_r)
        S_IDLE:
        begin
          if (s_start)
          begin
            snp_cur_r <= snp_q_r;
            s_state_r <= S_RD;
          end
        end
        S_RD:
        begin
          s_state_r <= S_WR;
        end
        S_WR:
        begin
          s_state_r <= S_IDLE;
        end
        default:
        begin
          s_state_r <= S_IDLE;
        end
      endcase
    end
  end

  // tag valid bits live in flops so a flush clears them all at once
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tv_a_r <= {SETS{1'b0}}; // RL4
      tv_b_r <= {SETS{1'b0}}; // RL4
    end
    else if (i_flush | ~run)
    begin
      tv_a_r <= {SETS{1'b0}}; // RL4
      tv_b_r <= {SETS{1'b0}}; // RL4
    end
    else if (fill_now)
    begin
      if (fill_b_r)
      begin
        tv_b_r[cur_set] <= 1'b1; // RL23
      end
      else
      begin
        tv_a_r[cur_set] <= 1'b1; // RL23
      end
    end
  end

  // replacement bit: 0 replaces bank a next, 1 replaces bank b
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lru_r <= {SETS{`TCD_LRU_RST}};
    end
    else if (snp_wr & (snp_hit_a | snp_hit_b))
    begin
      lru_r[snp_set] <= snp_hit_b; // RL3
    end
    else if ((m_state_r == M_CHK) & (rd_hit | wr_hit) & i_two_way)
    begin
      lru_r[cur_set] <= hit_a; // RL2 RL22
    end
    else if (fill_now & i_two_way)
    begin
      lru_r[cur_set] <= ~fill_b_r; // RL23
    end
  end
endmodule // tcd_ctrl

// >>> tb/tcd_ctrl_sva.sv
// tcd_ctrl_sva.sv: port-level assertions of the cache directory control
`timescale 1ns/1ps
module tcd_ctrl_chk (
  input wire       i_clk_sys,             // double-rate clock
  input wire       i_nrst,                // reset, active low
  input wire       i_cpu_ready_in_n,      // shared ready
  input wire       i_two_way,             // organisation
  input wire       i_out_en_style_sel_n,  // output enable style
  input wire       o_phase_clk,           // internal phase
  input wire       o_ctrl_ready_out_n,    // own ready
  input wire       o_sys_ready_gate_n,    // system ready gate
  input wire       o_next_addr_req_n,     // next address request
  input wire       o_cache_addr_latch_en, // address latch enable
  input wire       o_cache_xcvr_dir,      // transceiver direction
  input wire [3:0] o_cache_byte_sel_n,    // byte selects
  input wire       o_bank_a_out_en_n,     // bank a output enable
  input wire       o_bank_b_out_en_n,     // bank b output enable
  input wire       o_bank_a_wr_en_n,      // bank a write enable
  input wire       o_bank_b_wr_en_n       // bank b write enable
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire wr_any = !(o_bank_a_wr_en_n && o_bank_b_wr_en_n);
  wire oe_any = !(o_bank_a_out_en_n && o_bank_b_out_en_n);
  property p_phase_align; $rose(i_nrst) |-> !o_phase_clk [*3] ##1 o_phase_clk; endproperty
  a_phase_align: assert property (p_phase_align) else $error("phase misaligned after reset");
  property p_phase_fall; o_phase_clk |=> !o_phase_clk; endproperty
  a_phase_fall: assert property (p_phase_fall) else $error("phase two repeated");
  property p_phase_rise; !o_phase_clk && $past(o_phase_clk) |=> o_phase_clk; endproperty
  a_phase_rise: assert property (p_phase_rise) else $error("phase one repeated");
  property p_excl; !o_ctrl_ready_out_n |-> o_sys_ready_gate_n; endproperty
  a_excl: assert property (p_excl) else $error("own ready during forwarded read");
  property p_stand; !o_ctrl_ready_out_n && !(o_phase_clk && !i_cpu_ready_in_n) |=> !o_ctrl_ready_out_n; endproperty
  a_stand: assert property (p_stand) else $error("ready dropped before cycle end");
  property p_end; o_phase_clk && !i_cpu_ready_in_n && !o_ctrl_ready_out_n |=> o_ctrl_ready_out_n [*2]; endproperty
  a_end: assert property (p_end) else $error("ready held past cycle end");
  property p_na; !o_ctrl_ready_out_n || !o_sys_ready_gate_n |-> !o_next_addr_req_n; endproperty
  a_na: assert property (p_na) else $error("no next address request");
  property p_oe_hit;
    !i_out_en_style_sel_n && oe_any |-> !o_ctrl_ready_out_n && o_cache_xcvr_dir && !o_cache_addr_latch_en
      && o_cache_byte_sel_n == 4'h0 && !wr_any;
  endproperty
  a_oe_hit: assert property (p_oe_hit) else $error("output enable outside read hit");
  property p_tw_oe; i_two_way |-> o_bank_a_out_en_n || o_bank_b_out_en_n; endproperty
  a_tw_oe: assert property (p_tw_oe) else $error("both output enables in two-way");
  property p_tw_we; i_two_way |-> o_bank_a_wr_en_n || o_bank_b_wr_en_n; endproperty
  a_tw_we: assert property (p_tw_we) else $error("both write enables in two-way");
  property p_dm;
    !i_two_way |-> o_bank_a_wr_en_n == o_bank_b_wr_en_n && o_bank_a_out_en_n == o_bank_b_out_en_n;
  endproperty
  a_dm: assert property (p_dm) else $error("direct mapped banks differ");
  property p_fill; !o_sys_ready_gate_n && wr_any |-> o_cache_byte_sel_n == 4'h0 && !o_cache_xcvr_dir; endproperty
  a_fill: assert property (p_fill) else $error("fill not full line toward cache");
  property p_xcvr; o_cache_xcvr_dir |-> !wr_any; endproperty
  a_xcvr: assert property (p_xcvr) else $error("cache written while driving processor");
  property p_oe_hi; i_out_en_style_sel_n && wr_any |-> oe_any; endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("no output enable on cache write");
endmodule // tcd_ctrl_chk
bind tcd_ctrl tcd_ctrl_chk u_tcd_ctrl_chk (.*);

// >>> tb/tcd_host_model.sv
// tcd_host_model.sv: shared ready line with system bus and local device terminators
`timescale 1ns/1ps
module tcd_host_model #(
  parameter SYS_WAIT = 2
) (
  input  wire i_clk_sys,          // double-rate clock
  input  wire i_nrst,             // reset, active low
  input  wire i_phase,            // internal phase of the controller
  input  wire i_ctrl_ready_out_n, // controller ready
  input  wire i_sys_ready_gate_n, // system ready gate
  input  wire i_local_on,         // a local device is addressed
  output wire o_cpu_ready_in_n    // wired ready to processor
);
  reg  [3:0] wait_r;
  reg        sys_rdy_r;
  reg        loc_rdy_r;
  wire       want = !i_sys_ready_gate_n || i_local_on;
  // terminators answer only for one phase_two cycle, after a few states of wait
  always @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst || !want)
    begin
      wait_r    <= 4'h0;
      sys_rdy_r <= 1'b0;
      loc_rdy_r <= 1'b0;
    end
    else if (!i_phase)
    begin
      wait_r    <= wait_r + 4'h1;
      sys_rdy_r <= !i_sys_ready_gate_n && wait_r >= SYS_WAIT;
      loc_rdy_r <= i_local_on && wait_r >= SYS_WAIT;
    end
    else
    begin
      sys_rdy_r <= 1'b0;
      loc_rdy_r <= 1'b0;
    end
  end
  // system ready reaches the processor only through the gate
  assign o_cpu_ready_in_n = i_ctrl_ready_out_n & !sys_rdy_r & !loc_rdy_r;
endmodule // tcd_host_model

// >>> tb/tb.sv
// tb.sv: scenario testbench of the cache directory control
`timescale 1ns/1ps
module tb;
  reg         i_clk_sys = 1'b0, i_nrst = 1'b0, i_cpu_mio = 1'b1, i_cpu_wr = 1'b0, local_on = 1'b0;
  reg         i_cpu_addr_strobe_n = 1'b1, i_local_acc_n = 1'b1, i_non_cache_n = 1'b1;
  reg         i_two_way = 1'b1, i_out_en_style_sel_n = 1'b0, i_flush = 1'b0, i_snoop_req = 1'b0;
  reg  [31:2] i_cpu_addr = 30'h0, i_snoop_addr = 30'h0;
  reg  [3:0]  i_cpu_byte_en_n = 4'hf;
  wire        i_cpu_ready_in_n, o_phase_clk, o_ctrl_ready_out_n, o_sys_ready_gate_n, o_next_addr_req_n;
  wire        o_cache_addr_latch_en, o_cache_xcvr_dir, o_bank_a_out_en_n, o_bank_b_out_en_n;
  wire        o_bank_a_wr_en_n, o_bank_b_wr_en_n;
  wire [3:0]  o_cache_byte_sel_n;
  integer     err_count = 0;
  integer     samples_checked = 0;
  localparam [10:0] ALL = 11'h7ff;
  localparam [17:0] TX = 18'h00001, TY = 18'h00002, TZ = 18'h00003, TW = 18'h00004;
  always #4 i_clk_sys = ~i_clk_sys;
  tcd_ctrl u_tcd_ctrl (.i_bus16_n(1'b1), .*);
  tcd_host_model u_tcd_host_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_phase(o_phase_clk),
    .i_ctrl_ready_out_n(o_ctrl_ready_out_n), .i_sys_ready_gate_n(o_sys_ready_gate_n),
    .i_local_on(local_on), .o_cpu_ready_in_n(i_cpu_ready_in_n));
  // every address lands in one set and line so that the two ways compete
  function [31:2] adr(input [17:0] t);
    adr = {t, 9'h005, 3'h1};
  endfunction
  function [10:0] e(input ro, g, x, input [3:0] s, input oa, ob, wa, wb);
    e = {ro, g, x, s, oa, ob, wa, wb};
  endfunction
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task check(input string nm, input [10:0] ex, input [10:0] gt, input [10:0] m);
    begin
      samples_checked = samples_checked + 1;
      if ((gt & m) !== (ex & m))
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, ex & m, gt & m);
      end
    end
  endtask
  task do_reset(input tw, input st);
    begin
      @(posedge i_clk_sys);
      i_nrst <= 1'b0;
      i_two_way <= tw;
      i_out_en_style_sel_n <= st;
      repeat (8) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask
  // strobe in a phase_two cycle, drop decodes after the taking edge, capture strobes in the ending cycle
  task run(input [31:2] a, input [3:0] be, input w, m, ln, nn, loc, output [10:0] g);
    integer n;
    begin
      n = 0;
      @(negedge i_clk_sys);
      while (o_phase_clk !== 1'b0) @(negedge i_clk_sys);
      @(posedge i_clk_sys);
      i_cpu_addr <= a;
      i_cpu_byte_en_n <= be;
      i_cpu_wr <= w;
      i_cpu_mio <= m;
      i_cpu_addr_strobe_n <= 1'b0;
      i_local_acc_n <= ln;
      i_non_cache_n <= nn;
      local_on <= loc;
      @(posedge i_clk_sys);
      i_cpu_addr_strobe_n <= 1'b1;
      i_local_acc_n <= 1'b1;
      i_non_cache_n <= 1'b1;
      do
      begin
        @(negedge i_clk_sys);
        n = n + 1;
      end
      while (n < 300 && !(o_phase_clk === 1'b1 && i_cpu_ready_in_n === 1'b0));
      g = {o_ctrl_ready_out_n, o_sys_ready_gate_n, o_cache_xcvr_dir, o_cache_byte_sel_n,
           o_bank_a_out_en_n, o_bank_b_out_en_n, o_bank_a_wr_en_n, o_bank_b_wr_en_n};
      check("latch na", {10'h0, loc}, {9'h0, o_cache_addr_latch_en, o_next_addr_req_n}, ALL);
      if (n >= 300)
        check("cycle end", 11'h0, 11'h1, ALL);
      @(posedge i_clk_sys);
      local_on <= 1'b0;
    end
  endtask
  task t_two_way;
    reg [10:0] g;
    begin
      run(adr(TX), 4'h0, 0, 1, 1, 1, 0, g);
      check("fill a", e(1, 0, 0, 4'h0, 1, 1, 0, 1), g, ALL);
      run(adr(TY), 4'h0, 0, 1, 1, 1, 0, g);
      check("fill b", e(1, 0, 0, 4'h0, 1, 1, 1, 0), g, ALL);
      run(adr(TX), 4'ha, 1, 1, 1, 1, 0, g);
      check("write hit a", e(0, 1, 0, 4'ha, 1, 1, 0, 1), g, ALL);
      run(adr(TZ), 4'h0, 0, 1, 1, 1, 0, g);
      check("fill after write", e(1, 0, 0, 4'h0, 1, 1, 1, 0), g, ALL);
      run(adr(TX), 4'he, 0, 1, 1, 1, 0, g);
      check("read hit a", e(0, 1, 1, 4'h0, 0, 1, 1, 1), g, ALL);
      run(adr(TW), 4'h0, 0, 1, 1, 1, 0, g);
      check("fill after hit", e(1, 0, 0, 4'h0, 1, 1, 1, 0), g, ALL);
      $display("test two_way done");
    end
  endtask
  task t_snoop;
    reg [10:0] g;
    begin
      @(posedge i_clk_sys);
      i_snoop_addr <= adr(TW);
      i_snoop_req <= 1'b1;
      @(posedge i_clk_sys);
      i_snoop_req <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      run(adr(TZ), 4'h0, 0, 1, 1, 1, 0, g);
      check("fill after snoop", e(1, 0, 0, 4'h0, 1, 1, 1, 0), g, ALL);
      $display("test snoop done");
    end
  endtask
  task t_flush;
    reg [10:0] g;
    begin
      @(posedge i_clk_sys);
      i_flush <= 1'b1;
      @(posedge i_clk_sys);
      i_flush <= 1'b0;
      run(adr(TX), 4'h0, 0, 1, 1, 1, 0, g);
      check("read after flush", e(1, 0, 0, 4'h0, 1, 1, 0, 1), g, ALL);
      $display("test flush done");
    end
  endtask
  task t_other;
    reg [10:0] g;
    begin
      run(adr(TX), 4'h0, 0, 1, 0, 1, 1, g);
      check("local read", e(1, 1, 0, 4'hf, 1, 1, 1, 1), g, ALL);
      run({1'b1, 29'h0}, 4'h0, 1, 0, 1, 1, 1, g);
      check("coprocessor", e(1, 1, 0, 4'hf, 1, 1, 1, 1), g, ALL);
      run(adr(TX), 4'h0, 0, 1, 1, 0, 0, g);
      check("non cacheable", e(1, 0, 0, 4'hf, 1, 1, 1, 1), g, ALL);
      run(adr(TY), 4'h3, 1, 0, 1, 1, 0, g);
      check("io write", e(0, 1, 0, 4'hf, 1, 1, 1, 1), g, ALL);
      $display("test other done");
    end
  endtask
  task t_direct;
    reg [10:0] g;
    begin
      do_reset(1'b0, 1'b1);
      run(adr(TX), 4'h0, 0, 1, 1, 1, 0, g);
      check("dm fill", e(1, 0, 0, 4'h0, 0, 0, 0, 0), g, ALL);
      run(adr(TX), 4'h7, 0, 1, 1, 1, 0, g);
      check("dm read hit", e(0, 1, 1, 4'h0, 0, 0, 1, 1), g, ALL);
      run(adr(TX), 4'h5, 1, 1, 1, 1, 0, g);
      check("dm write hit", e(0, 1, 0, 4'h5, 0, 0, 0, 0), g, ALL);
      $display("test direct done");
    end
  endtask
  initial
  begin
    do_reset(1'b1, 1'b0);
    t_two_way;
    t_snoop;
    t_flush;
    t_other;
    t_direct;
    wrap_up;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    wrap_up;
  end
endmodule // tb
